// file: lcis_defines.vh
`ifndef LCIS_DEFINES_VH
`define LCIS_DEFINES_VH
// Register byte offsets, one aligned word per multiplexer plus one status word.
`define LCIS_SEL_REG_FIRST_OFS 5'h00
`define LCIS_SEL_REG_1_OFS 5'h04
`define LCIS_SEL_REG_2_OFS 5'h08
`define LCIS_SEL_REG_LAST_OFS 5'h0c
`define LCIS_STATUS_OFS 5'h10
// Select code field.
`define LCIS_CODE_MSB 5
`define LCIS_CODE_LSB 0
`define LCIS_CODE_RESET 6'h00
// Number of candidate signals; codes at or above this are reserved.
`define LCIS_NUM_SOURCES 6'h25
`define LCIS_NUM_MUX 4
// AXI responses.
`define LCIS_RESP_OKAY 2'b00
`define LCIS_RESP_SLVERR 2'b10
`endif

// file: lcis_code_mem.v
`timescale 1ns/10ps
`default_nettype none
`include "lcis_defines.vh"
// Four select codes held as a tiny memory with a registered read port.
module lcis_code_mem (
  input wire aclk,
  input wire aresetn,
  input wire wr_en,
  input wire [1:0] wr_idx,
  input wire [5:0] wr_code,
  input wire [1:0] rd_idx,
  output reg [5:0] rd_code,
  output wire [23:0] all_codes
);
  reg [5:0] code_reg [0:3];
  integer i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < `LCIS_NUM_MUX; i = i + 1) begin
        code_reg[i] <= `LCIS_CODE_RESET;
      end
      rd_code <= `LCIS_CODE_RESET;
    end else begin
      if (wr_en) begin
        code_reg[wr_idx] <= wr_code;
      end
      rd_code <= code_reg[rd_idx];
    end
  end

  assign all_codes = {code_reg[3], code_reg[2], code_reg[1], code_reg[0]};
endmodule // lcis_code_mem
`default_nettype wire

// file: lcis_input_select.v
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "lcis_defines.vh"
module lcis_input_select (
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] cell_external_input,
  input wire system_clock,
  input wire high_freq_internal_osc,
  input wire low_freq_internal_osc,
  input wire medium_freq_internal_osc_500k,
  input wire medium_freq_internal_osc_32k,
  input wire secondary_oscillator,
  input wire converter_rc_oscillator,
  input wire [3:0] timer_overflow,
  input wire signal_measurement_timer_overflow,
  input wire capture_compare_unit_one,
  input wire capture_compare_unit_two,
  input wire pulse_width_unit_three,
  input wire pulse_width_unit_four,
  input wire comparator_one_result,
  input wire comparator_two_result,
  input wire zero_cross_detector,
  input wire pin_change_interrupt_flag,
  input wire [3:0] configurable_logic_cell_out,
  input wire first_serial_port_data,
  input wire first_serial_port_clock,
  input wire sync_serial_port_data_out,
  input wire sync_serial_port_clock,
  input wire real_time_calendar_seconds,
  input wire waveform_gen_output_a,
  input wire waveform_gen_output_b,
  input wire second_serial_port_data,
  input wire second_serial_port_clock,
  output reg [3:0] cell_data_out,
  output reg [3:0] reserved_code_seen
);
  // Protection bits are ignored, so every access is treated alike.
  reg [4:0] wr_addr_reg;
  reg [31:0] wr_data_reg;
  reg [3:0] wr_strb_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg rd_pend_reg;
  reg [4:0] rd_addr_reg;
  wire [23:0] all_codes;
  wire [5:0] rd_code;
  wire [63:0] src_vec;
  wire do_write;
  wire wr_is_sel;
  integer m;

  function is_sel_addr;
    input [4:0] a;
    begin
      is_sel_addr = (a[1:0] == 2'b00) && (a[4] == 1'b0);
    end
  endfunction

  // Codes at or above the source count are reserved and select nothing.
  function is_reserved_code;
    input [5:0] c;
    begin
      is_reserved_code = (c >= `LCIS_NUM_SOURCES);
    end
  endfunction

  // Codes 0x25 and up read from the tied-low upper slice.
  assign src_vec = {27'h0000000,
                    second_serial_port_clock, second_serial_port_data,
                    waveform_gen_output_b, waveform_gen_output_a,
                    real_time_calendar_seconds,
                    sync_serial_port_clock, sync_serial_port_data_out,
                    first_serial_port_clock, first_serial_port_data,
                    configurable_logic_cell_out,
                    pin_change_interrupt_flag, zero_cross_detector,
                    comparator_two_result, comparator_one_result,
                    pulse_width_unit_four, pulse_width_unit_three,
                    capture_compare_unit_two, capture_compare_unit_one,
                    signal_measurement_timer_overflow, timer_overflow,
                    converter_rc_oscillator, secondary_oscillator,
                    medium_freq_internal_osc_32k, medium_freq_internal_osc_500k,
                    low_freq_internal_osc, high_freq_internal_osc, system_clock,
                    cell_external_input};

  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_is_sel = is_sel_addr(wr_addr_reg);

  // Only byte lane zero carries a code, so a write without it keeps the old one.
  // The read index comes straight from the bus, so the code is fetched at the handshake.
  lcis_code_mem u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(do_write && wr_is_sel && wr_strb_reg[0]),
    .wr_idx(wr_addr_reg[3:2]),
    .wr_code(wr_data_reg[`LCIS_CODE_MSB:`LCIS_CODE_LSB]),
    .rd_idx(s_axi_araddr[3:2]),
    .rd_code(rd_code),
    .all_codes(all_codes)
  );

  // Outputs are registered, so a rewrite shows one cycle after it lands.
  // A reserved code indexes the tied-low slice, so no extra gating is needed.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cell_data_out <= 4'h0;
      reserved_code_seen <= 4'h0;
    end else begin
      for (m = 0; m < `LCIS_NUM_MUX; m = m + 1) begin
        cell_data_out[m] <= src_vec[all_codes[m*6 +: 6]];
        reserved_code_seen[m] <= is_reserved_code(all_codes[m*6 +: 6]);
      end
    end
  end

  // Address and data are latched on their own handshakes, so either may come first.
  // Both readies stay low until the response is taken, keeping one write in flight.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LCIS_RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_addr_reg <= 5'h00;
      wr_data_reg <= 32'h00000000;
      wr_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data_reg <= s_axi_wdata;
        wr_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_is_sel ? `LCIS_RESP_OKAY : `LCIS_RESP_SLVERR;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Reads take two cycles because the code memory has a registered port.
  // An unmapped offset answers with an error and zero data.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LCIS_RESP_OKAY;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 5'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rd_pend_reg <= 1'b1;
        rd_addr_reg <= s_axi_araddr;
      end
      if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if (is_sel_addr(rd_addr_reg)) begin
          s_axi_rdata <= {26'h0000000, rd_code};
          s_axi_rresp <= `LCIS_RESP_OKAY;
        end else if (rd_addr_reg == `LCIS_STATUS_OFS) begin
          s_axi_rdata <= {24'h000000, reserved_code_seen, cell_data_out};
          s_axi_rresp <= `LCIS_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `LCIS_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // lcis_input_select
`default_nettype wire

// file: lcis_gate_model.sv
`timescale 1ns/10ps
`default_nettype none
module lcis_gate_model (
  input wire logic aclk,
  input wire logic [3:0] cell_data_out,
  output logic [3:0] gated
);
  always @(posedge aclk) begin
    gated <= cell_data_out;
  end
endmodule // lcis_gate_model
`default_nettype wire

// file: lcis_input_select_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module lcis_input_select_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0] cell_data_out,
  input wire logic [3:0] reserved_code_seen
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_ans; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  property p_rd_ans; s_rd_taken |-> ##2 s_axi_rvalid; endproperty
  property p_ar_lock; s_rd_taken |=> !s_axi_arready; endproperty
  property p_aw_lock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rst;
    $rose(aresetn) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_b_back; s_axi_bvalid && s_axi_bready |=> s_axi_awready && !s_axi_bvalid; endproperty
  // A reserved code that has stood two cycles must have silenced its output.
  property p_rsv; (reserved_code_seen & $past(reserved_code_seen) & cell_data_out) == 4'h0;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  a_ar_lock: assert property (p_ar_lock) else $error("read not locked");
  a_aw_lock: assert property (p_aw_lock) else $error("write not locked");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_rst: assert property (p_rst) else $error("bad reset state");
  a_b_back: assert property (p_b_back) else $error("write not freed");
  a_rsv: assert property (p_rsv) else $error("reserved output high");
endmodule // lcis_input_select_chk
bind lcis_input_select lcis_input_select_chk i_chk (.*);
`default_nettype wire

// file: lcis_input_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "lcis_defines.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module lcis_input_select_tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [3:0] cell_data_out, reserved_code_seen, gated;
  logic [36:0] s = 0;
  logic [5:0] codes [4] = '{default: 6'h00};
  logic [1:0] r;
  logic [3:0] ev;
  int fail_count = 0, n_tests = 0, cyc = 0, m;
  always #25 aclk = ~aclk;
  lcis_input_select i_dut (.*, .cell_external_input(s[3:0]), .system_clock(s[4]),
    .high_freq_internal_osc(s[5]), .low_freq_internal_osc(s[6]),
    .medium_freq_internal_osc_500k(s[7]), .medium_freq_internal_osc_32k(s[8]),
    .secondary_oscillator(s[9]), .converter_rc_oscillator(s[10]), .timer_overflow(s[14:11]),
    .signal_measurement_timer_overflow(s[15]), .capture_compare_unit_one(s[16]),
    .capture_compare_unit_two(s[17]), .pulse_width_unit_three(s[18]),
    .pulse_width_unit_four(s[19]), .comparator_one_result(s[20]),
    .comparator_two_result(s[21]), .zero_cross_detector(s[22]),
    .pin_change_interrupt_flag(s[23]), .configurable_logic_cell_out(s[27:24]),
    .first_serial_port_data(s[28]), .first_serial_port_clock(s[29]),
    .sync_serial_port_data_out(s[30]), .sync_serial_port_clock(s[31]),
    .real_time_calendar_seconds(s[32]), .waveform_gen_output_a(s[33]),
    .waveform_gen_output_b(s[34]), .second_serial_port_data(s[35]),
    .second_serial_port_clock(s[36]));
  lcis_gate_model i_gate (.aclk(aclk), .cell_data_out(cell_data_out), .gated(gated));
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      close_out();
    end
  end
  function automatic logic exp_bit(input logic [5:0] c, input logic [36:0] v);
    return (c < 6'h25) ? v[c] : 1'b0;
  endfunction
  task automatic wr(input logic [4:0] a, input logic [31:0] wd, output logic [1:0] wr_r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    wr_r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  // The read ready is raised late at random so the slave must hold its answer.
  task automatic rd(input logic [4:0] a, output logic [31:0] rd_d, output logic [1:0] rd_r);
    int k = $urandom_range(3);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (k-- == 0) s_axi_rready <= 1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  initial begin
    void'($urandom(4));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 4; i++) begin
      rd(5'(i * 4), d, r);
      `CHK("reset code", 32'h0, d)
    end
    for (int c = 0; c < 64; c++) begin
      m = c % 4;
      d = $urandom();
      d[5:0] = 6'(c);
      wr(5'(m * 4), d, r);
      codes[m] = 6'(c);
      `CHK("bresp", `LCIS_RESP_OKAY, r)
      rd(5'(m * 4), d, r);
      `CHK("readback", {26'h0, codes[m]}, d)
      repeat (3) begin
        @(posedge aclk);
        s <= 37'({$urandom(), $urandom()});
        @(posedge aclk);
        @(negedge aclk);
        for (int i = 0; i < 4; i++) begin
          ev[i] = exp_bit(codes[i], s);
          `CHK("mux", ev[i], cell_data_out[i])
          `CHK("flag", codes[i] >= 6'h25, reserved_code_seen[i])
        end
        @(negedge aclk);
        `CHK("gated", ev, gated)
      end
    end
    @(posedge aclk);
    s_axi_wstrb <= 4'he;
    wr(5'h00, 32'h00000005, r);
    s_axi_wstrb <= 4'hf;
    `CHK("strobe bresp", `LCIS_RESP_OKAY, r)
    rd(5'h00, d, r);
    `CHK("strobe keep", {26'h0, codes[0]}, d)
    wr(5'h10, 32'h1, r);
    `CHK("status write", `LCIS_RESP_SLVERR, r)
    rd(5'h10, d, r);
    `CHK("status", 32'hf0, d)
    rd(5'h14, d, r);
    `CHK("unmapped", {`LCIS_RESP_SLVERR, 32'h0}, {r, d})
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 4; i++) begin
      rd(5'(i * 4), d, r);
      `CHK("rerun code", 32'h0, d)
    end
    rd(5'h10, d, r);
    `CHK("rerun status", {28'h0, {4{s[0]}}}, d)
    close_out();
  end
endmodule // lcis_input_select_tb
`default_nettype wire
